/* verilog/keq_map.svh */
// Purpose: Offsets, fields, resets and timing of the key event queue
// Assumes: 250 MHz core clock
// Notes: Definitions only
//
// Behaviour
// - Combo detect sets flag 4, W1C
// - Queue overflow sets flag 3, W1C
// - Unlock sequence sets flag 2, W1C
// - GP input event sets flag 1, W1C
// - Press or release sets flag 0, W1C
// - Enabled set flag drives host interrupt low
// - Combo flag drives its own pin
// - No clear while source still pending
// - Bit 6 write locks or unlocks keypad
// - Bits 5,4 report lock state
// - Bits 3:0 count queued events, 0..10
// - Queue holds ten one-byte entries
// - Head read pops, count minus one
// - Entry bits 6:0 carry key number
// - Entry bit 7 is press
// - Simultaneous presses queue separately, all interrupt
// - Key flag holds until queue empty
// - Empty head read returns zero
// - Nonzero window field enables keylock
// - Mask timer gives first-press key interrupt
// - Either timer expiry resets lock sequence
// - Overflow drops newest or overwrites oldest
// - Zero unlock key disables keylock
// - Reassert mode releases interrupt 50 us
`ifndef KEQ_MAP_SVH
`define KEQ_MAP_SVH
`define KEQ_ADDR_FLAGS 8'h02
`define KEQ_ADDR_LOCK 8'h03
`define KEQ_ADDR_HEAD 8'h04
`define KEQ_ADDR_TIMING 8'h0E
`define KEQ_FLAG_COMBO 4
`define KEQ_FLAG_OVF 3
`define KEQ_FLAG_LOCK 2
`define KEQ_FLAG_GPI 1
`define KEQ_FLAG_KEY 0
`define KEQ_LOCK_REQ_BIT 6
`define KEQ_CFG_OVW 5
`define KEQ_CFG_REASSERT 4
`define KEQ_QUEUE_DEPTH 10
`define KEQ_TIMING_RST 8'h00
`define KEQ_COMBO_K0 7'h01
`define KEQ_COMBO_K1 7'h0B
`define KEQ_COMBO_K2 7'h15
`define KEQ_CLK_MHZ 250
`define KEQ_REASSERT_US 50
`define KEQ_REASSERT_CYC (`KEQ_REASSERT_US * `KEQ_CLK_MHZ)
`define KEQ_SEC_S 1
`define KEQ_SEC_CYC (`KEQ_SEC_S * `KEQ_CLK_MHZ * 1000000)
`define KEQ_HOLD_W 16
`endif

/* verilog/keq_pkg.sv */
// Purpose: Shared types of the key event queue
// Assumes: Nothing
// Notes: Constants live in keq_map.svh
`default_nettype none
package keq_pkg;
  typedef logic [7:0] entry_t;
  typedef enum logic [0:0] {LK_IDLE = 1'b0, LK_WAIT2 = 1'b1} lock_state_t;
endpackage
`default_nettype wire

/* verilog/keq_if.sv */
// Purpose: Links between top, queue and keylock sequencer
// Assumes: All on i_mclk
// Notes: Pure wiring
`timescale 1ns/1ps
`default_nettype none
interface keq_if;
  import keq_pkg::*;
  logic push;
  entry_t push_data;
  logic pop;
  logic ovw_mode;
  logic [3:0] count;
  entry_t head;
  logic overflow;
  logic evt_valid;
  entry_t evt_code;
  logic lock_active;
  logic [7:0] timing;
  logic [6:0] key1;
  logic [6:0] key2;
  logic unlock_done;
  logic first_press;
  logic mid_seq;
  modport fifo (input push, push_data, pop, ovw_mode,
    output count, head, overflow);
  modport lock (input evt_valid, evt_code, lock_active, timing, key1, key2,
    output unlock_done, first_press, mid_seq);
endinterface
`default_nettype wire

/* verilog/event_fifo.sv */
// Purpose: Shift-register event queue, head at entry 0
// Assumes: One pop and one push per cycle at most
// Notes: Pop is applied before push
`timescale 1ns/1ps
`default_nettype none
`include "keq_map.svh"
module event_fifo
  import keq_pkg::*;
#(
  parameter int DEPTH = `KEQ_QUEUE_DEPTH
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  keq_if.fifo f
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [3:0] count;
    logic ovf;
  } st_t;
  st_t q;
  st_t d;

  // ==========================================================
  // Queue update
  always_comb
  begin
    d = q;
    d.ovf = 1'b0;
    // Entries slide toward the head; vacated top reads zero
    if (f.pop && q.count != 4'h0)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        d.mem[i] = q.mem[i+1];
      d.mem[DEPTH-1] = 8'h00;
      d.count = q.count - 4'h1;
    end
    if (f.push)
    begin
      if (d.count == 4'(DEPTH))
      begin
        d.ovf = 1'b1;
        // Drop newest unless overwrite mode is on
        if (f.ovw_mode)
        begin
          for (int i = 0; i < DEPTH - 1; i++)
            d.mem[i] = d.mem[i+1];
          d.mem[DEPTH-1] = f.push_data;
        end
      end
      else
      begin
        d.mem[d.count] = f.push_data;
        d.count = d.count + 4'h1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      q <= '0;
    else
      q <= d;
  end

  assign f.count = q.count;
  assign f.head = q.mem[0];
  assign f.overflow = q.ovf;
endmodule
`default_nettype wire

/* verilog/keylock_fsm.sv */
// Purpose: Unlock key sequencer with window and mask timers
// Assumes: Events arrive as single-cycle strobes
// Notes: Both timers share one seconds prescaler
`timescale 1ns/1ps
`default_nettype none
`include "keq_map.svh"
module keylock_fsm
  import keq_pkg::*;
#(
  parameter int SEC_CYCLES = `KEQ_SEC_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  keq_if.lock l
);
  typedef struct packed {
    lock_state_t st;
    logic [27:0] pre;
    logic [2:0] secs;
    logic masking;
    logic [4:0] mask_secs;
    logic done;
    logic first;
  } st_t;
  st_t q;
  st_t d;
  logic tick;
  logic press;

  assign tick = q.pre == 28'(SEC_CYCLES - 1);
  assign press = l.evt_valid && l.evt_code[7] && l.lock_active;

  // ==========================================================
  // Sequencer and timers
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.first = 1'b0;
    d.pre = tick ? 28'h0 : q.pre + 28'h1;
    // Mask timer; one-second granularity, may run short by <1 s
    if (q.masking && tick)
    begin
      d.mask_secs = q.mask_secs + 5'h1;
      if (d.mask_secs >= l.timing[7:3])
      begin
        d.masking = 1'b0;
        d.st = LK_IDLE;
      end
    end
    if (press && l.timing[7:3] != 5'h00 && !q.masking)
    begin
      d.first = 1'b1;
      d.masking = 1'b1;
      d.mask_secs = 5'h00;
    end
    case (q.st)
      LK_IDLE:
      begin
        if (press && l.evt_code[6:0] == l.key1)
        begin
          d.st = LK_WAIT2;
          d.secs = 3'h0;
          d.pre = 28'h0;
        end
      end
      LK_WAIT2:
      begin
        if (press)
        begin
          d.st = LK_IDLE;
          d.done = l.evt_code[6:0] == l.key2;
        end
        else if (tick)
        begin
          d.secs = q.secs + 3'h1;
          if (d.secs >= l.timing[2:0])
            d.st = LK_IDLE;
        end
      end
      default: d.st = LK_IDLE;
    endcase
    // Nothing to sequence while unlocked
    if (!l.lock_active)
    begin
      d.st = LK_IDLE;
      d.masking = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      q <= '0;
    else
      q <= d;
  end

  assign l.unlock_done = q.done;
  assign l.first_press = q.first;
  assign l.mid_seq = q.st == LK_WAIT2;
endmodule
`default_nettype wire

/* verilog/key_event_queue_and_lock.sv */
// Purpose: Event flags, lock control, event queue and lock timing
// Assumes: Register strobes and scan events come from i_mclk logic
// Notes: Read data appears one cycle after i_reg_rd
`timescale 1ns/1ps
`default_nettype none
`include "keq_map.svh"
module key_event_queue_and_lock
  import keq_pkg::*;
#(
  parameter int REASSERT_CYCLES = `KEQ_REASSERT_CYC,
  parameter int SEC_CYCLES = `KEQ_SEC_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_evt_valid,
  input wire logic [7:0] i_evt_code,
  input wire logic i_gpi_event,
  input wire logic i_gpi_pending,
  input wire logic [7:0] i_cfg,
  input wire logic [7:0] i_unlock_key1,
  input wire logic [7:0] i_unlock_key2,
  output logic o_host_int_n,
  output logic o_host_int_oe,
  output logic o_combo_detect_n,
  output logic o_combo_detect_oe,
  output logic o_locked
);
  typedef struct packed {
    logic [4:0] flags;
    logic lock_req;
    logic [7:0] timing;
    logic [7:0] rdata;
    logic [2:0] combo;
    logic [`KEQ_HOLD_W-1:0] hold;
  } st_t;
  st_t q;
  st_t d;

  keq_if lk ();

  logic keys_ok;
  logic lock_active;
  logic wr_flags;
  logic [4:0] set_v;
  logic [4:0] clr_v;
  logic [4:0] pending;
  logic [2:0] combo_hit;

  // Matches a key number against the three combo keys
  function automatic logic [2:0] combo_match(input logic [6:0] key);
    combo_match = {key == `KEQ_COMBO_K2, key == `KEQ_COMBO_K1,
      key == `KEQ_COMBO_K0};
  endfunction

  // ==========================================================
  // Keylock qualification
  assign keys_ok = i_unlock_key1[6:0] != 7'h00 &&
    i_unlock_key2[6:0] != 7'h00;
  assign lock_active = q.lock_req && keys_ok &&
    q.timing[2:0] != 3'h0;

  // Locked keypad diverts events to the sequencer, not the queue
  assign lk.push = i_evt_valid && !lock_active;
  assign lk.push_data = i_evt_code;
  assign lk.pop = i_reg_rd && i_reg_addr == `KEQ_ADDR_HEAD;
  assign lk.ovw_mode = i_cfg[`KEQ_CFG_OVW];
  assign lk.evt_valid = i_evt_valid;
  assign lk.evt_code = i_evt_code;
  assign lk.lock_active = lock_active;
  assign lk.timing = q.timing;
  assign lk.key1 = i_unlock_key1[6:0];
  assign lk.key2 = i_unlock_key2[6:0];

  event_fifo #(
    .DEPTH(`KEQ_QUEUE_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(lk.fifo)
  );

  keylock_fsm #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_lock (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .l(lk.lock)
  );

  // ==========================================================
  // Flag sources, clear qualifiers
  assign combo_hit = combo_match(i_evt_code[6:0]);
  assign wr_flags = i_reg_wr && i_reg_addr == `KEQ_ADDR_FLAGS;
  // Sources still holding data keep their flag up
  assign pending = {3'b000, i_gpi_pending, lk.count != 4'h0};
  assign clr_v = wr_flags ? (i_reg_wdata[4:0] & ~pending) : 5'h00;

  always_comb
  begin
    set_v = 5'h00;
    set_v[`KEQ_FLAG_KEY] = lk.push || lk.first_press;
    set_v[`KEQ_FLAG_GPI] = i_gpi_event;
    set_v[`KEQ_FLAG_LOCK] = lk.unlock_done;
    set_v[`KEQ_FLAG_OVF] = lk.overflow;
    // Combo fires on the press that completes all three keys
    set_v[`KEQ_FLAG_COMBO] = i_evt_valid && i_evt_code[7] &&
      combo_hit != 3'b000 && ((q.combo | combo_hit) == 3'b111) &&
      q.combo != 3'b111;
  end

  // ==========================================================
  // Register state update
  always_comb
  begin
    d = q;
    // Set wins over a same-cycle clear
    d.flags = (q.flags & ~clr_v) | set_v;
    // Track held combo keys
    if (i_evt_valid)
    begin
      if (i_evt_code[7])
        d.combo = q.combo | combo_hit;
      else
        d.combo = q.combo & ~combo_hit;
    end
    // Reassert window after a refused clear
    if (q.hold != '0)
      d.hold = q.hold - `KEQ_HOLD_W'(1);
    if (wr_flags && i_cfg[`KEQ_CFG_REASSERT] &&
      (i_reg_wdata[4:0] & pending & q.flags) != 5'h00)
      d.hold = `KEQ_HOLD_W'(REASSERT_CYCLES);
    // Host writes
    if (i_reg_wr)
    begin
      if (i_reg_addr == `KEQ_ADDR_LOCK)
        d.lock_req = i_reg_wdata[`KEQ_LOCK_REQ_BIT];
      else if (i_reg_addr == `KEQ_ADDR_TIMING)
        d.timing = i_reg_wdata;
    end
    // Correct unlock sequence releases the lock
    if (lk.unlock_done)
      d.lock_req = 1'b0;
    // Host reads, registered
    if (i_reg_rd)
    begin
      if (i_reg_addr == `KEQ_ADDR_FLAGS)
        d.rdata = {3'b000, q.flags};
      else if (i_reg_addr == `KEQ_ADDR_LOCK)
        d.rdata = {1'b0, q.lock_req, lock_active,
          lock_active && !lk.mid_seq, lk.count};
      else if (i_reg_addr == `KEQ_ADDR_HEAD)
        d.rdata = lk.head;
      else if (i_reg_addr == `KEQ_ADDR_TIMING)
        d.rdata = q.timing;
      else
        d.rdata = 8'h00;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      q <= '0;
      q.timing <= `KEQ_TIMING_RST;
    end
    else
      q <= d;
  end

  // ==========================================================
  // Pins; open drain, enable high pulls low
  assign o_host_int_oe = ((q.flags[3:0] & i_cfg[3:0]) != 4'h0) &&
    q.hold == '0;
  assign o_host_int_n = !o_host_int_oe;
  assign o_combo_detect_oe = q.flags[`KEQ_FLAG_COMBO];
  assign o_combo_detect_n = !o_combo_detect_oe;
  assign o_reg_rdata = q.rdata;
  assign o_locked = lock_active;
endmodule
`default_nettype wire

/* dv/keq_chk.sv */
// Purpose: Port assertions for the event queue block
// Assumes: One clock domain, reset low
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module keq_chk
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_evt_valid,
  input wire logic [7:0] i_cfg,
  input wire logic [7:0] i_unlock_key1,
  input wire logic [7:0] i_unlock_key2,
  input wire logic o_host_int_n,
  input wire logic o_host_int_oe,
  input wire logic o_combo_detect_n,
  input wire logic o_combo_detect_oe,
  input wire logic o_locked
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  // ==========
  // Pins follow their enables
  a_int_pin_pair: assert property (o_host_int_n == !o_host_int_oe)
    else $error("int pin");
  a_combo_pin_pair: assert property (
    o_combo_detect_n == !o_combo_detect_oe)
    else $error("combo pin");
  // Reassert mode excluded: it may hold the pin off
  a_key_evt_int: assert property (i_evt_valid && !o_locked
    && i_cfg[0] && !i_cfg[4] |=> o_host_int_oe)
    else $error("event int");
  // Only a one written to bit 4 may drop the combo pin
  a_combo_sticky: assert property (o_combo_detect_oe
    && !(i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata[4])
    |=> o_combo_detect_oe)
    else $error("combo clear");
  // ==========
  // Read data
  a_flags_top_zero: assert property (i_reg_rd
    && i_reg_addr == 8'h02 |=> o_reg_rdata[7:5] == 3'h0)
    else $error("flag bits");
  a_count_max: assert property (i_reg_rd && i_reg_addr == 8'h03
    |=> o_reg_rdata[3:0] <= 4'hA)
    else $error("count");
  a_lock_pair: assert property (i_reg_rd && i_reg_addr == 8'h03
    |=> o_reg_rdata[5] == $past(o_locked) && !o_reg_rdata[7]
    && (o_reg_rdata[5] || !o_reg_rdata[4]))
    else $error("lock bits");
  // Stable keys guard a lock view decoded from the live keys
  a_unlock_keys: assert property (o_locked && $stable(i_unlock_key1)
    && $stable(i_unlock_key2) |-> i_unlock_key1[6:0] != 7'h00
    && i_unlock_key2[6:0] != 7'h00)
    else $error("zero key");
endmodule
bind key_event_queue_and_lock keq_chk u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_evt_valid(i_evt_valid), .i_cfg(i_cfg),
  .i_unlock_key1(i_unlock_key1), .i_unlock_key2(i_unlock_key2),
  .o_host_int_n(o_host_int_n), .o_host_int_oe(o_host_int_oe),
  .o_combo_detect_n(o_combo_detect_n),
  .o_combo_detect_oe(o_combo_detect_oe), .o_locked(o_locked));
`default_nettype wire

/* dv/keq_host.sv */
// Purpose: Host model polling the event queue registers
// Assumes: Strobes taken on the rising edge
// Notes: Idle bus shows inverted last values
`timescale 1ns/1ps
`default_nettype none
module keq_host
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0
);
  // ==========
  // Single-byte accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // Data taken once the answer cycle has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
  // Status, count, status again, one head read per event
  task automatic drain(output logic [7:0] q[$]);
    logic [7:0] s, c, e;
    rd(8'h02, s);
    rd(8'h03, c);
    rd(8'h02, s);
    q = {};
    repeat (c[3:0])
    begin
      rd(8'h04, e);
      q.push_back(e);
    end
    wr(8'h02, 8'h01);
  endtask
endmodule
`default_nettype wire

/* dv/key_event_queue_and_lock_tb_top.sv */
// Purpose: Self-checking bench of the event queue block
// Assumes: Host model drives the register strobes
// Notes: Timers shortened through parameters
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module key_event_queue_and_lock_tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, int_n, int_oe, combo_n, combo_oe, locked;
  logic [7:0] code = 8'h00, cfg = 8'h00, key1 = 8'h05, key2 = 8'h06;
  logic evt = 1'b0, gpi = 1'b0, gpend = 1'b0;
  int err_count = 0, check_count = 0, cycles = 0;
  logic [7:0] q[$];
  always #2 mclk = ~mclk;
  key_event_queue_and_lock #(.REASSERT_CYCLES(20), .SEC_CYCLES(50)) u_dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_evt_valid(evt), .i_evt_code(code), .i_gpi_event(gpi),
    .i_gpi_pending(gpend), .i_cfg(cfg), .i_unlock_key1(key1),
    .i_unlock_key2(key2), .o_host_int_n(int_n), .o_host_int_oe(int_oe),
    .o_combo_detect_n(combo_n), .o_combo_detect_oe(combo_oe),
    .o_locked(locked));
  keq_host u_host (.i_clk(mclk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // ==========
  // Shared drivers
  task automatic push(input logic [7:0] c[$]);
    foreach (c[i])
    begin
      @(posedge mclk);
      evt <= 1'b1;
      code <= c[i];
    end
    @(posedge mclk);
    evt <= 1'b0;
    code <= ~code;
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    reg_is(8'h02, 8'h00);
    reg_is(8'h03, 8'h00);
    reg_is(8'h04, 8'h00);
    reg_is(8'h0E, 8'h00);
    reg_is(8'h7F, 8'h00);
    `CHK(int_n, 1'b1)
    $display("t_reset done");
  endtask
  task automatic t_queue;
    @(posedge mclk);
    cfg <= 8'h01;
    push({8'h81, 8'h8B, 8'h01});
    reg_is(8'h03, 8'h03);
    `CHK(int_n, 1'b0)
    `CHK(int_oe, 1'b1)
    u_host.wr(8'h02, 8'h01);
    reg_is(8'h02, 8'h01);
    u_host.drain(q);
    `CHK(q[0], 8'h81)
    `CHK(q[1], 8'h8B)
    `CHK(q[2], 8'h01)
    reg_is(8'h02, 8'h00);
    `CHK(int_n, 1'b1)
    reg_is(8'h04, 8'h00);
    $display("t_queue done");
  endtask
  // Eleven releases into ten places, drop newest then oldest
  task automatic t_overflow;
    logic [7:0] c[$];
    for (int m = 0; m < 2; m++)
    begin
      c = {};
      for (int k = 1; k <= 11; k++)
        c.push_back(8'(k));
      @(posedge mclk);
      cfg <= m ? 8'h28 : 8'h08;
      push(c);
      reg_is(8'h03, 8'h0A);
      reg_is(8'h02, 8'h09);
      `CHK(int_n, 1'b0)
      u_host.drain(q);
      `CHK(q[0], 8'(m + 1))
      `CHK(q[9], 8'(m + 10))
      u_host.wr(8'h02, 8'h08);
      reg_is(8'h02, 8'h00);
    end
    $display("t_overflow done");
  endtask
  task automatic t_combo;
    @(posedge mclk);
    cfg <= 8'h00;
    push({8'h81, 8'h8B, 8'h95});
    reg_is(8'h02, 8'h11);
    `CHK(combo_n, 1'b0)
    `CHK(combo_oe, 1'b1)
    `CHK(int_n, 1'b1)
    u_host.drain(q);
    `CHK(q[2], 8'h95)
    u_host.wr(8'h02, 8'h10);
    reg_is(8'h02, 8'h00);
    `CHK(combo_n, 1'b1)
    $display("t_combo done");
  endtask
  task automatic t_gpi;
    @(posedge mclk);
    gpend <= 1'b1;
    gpi <= 1'b1;
    @(posedge mclk);
    gpi <= 1'b0;
    u_host.wr(8'h02, 8'h02);
    reg_is(8'h02, 8'h02);
    @(posedge mclk);
    gpend <= 1'b0;
    u_host.wr(8'h02, 8'h02);
    reg_is(8'h02, 8'h00);
    $display("t_gpi done");
  endtask
  task automatic t_lock;
    @(posedge mclk);
    cfg <= 8'h04;
    u_host.wr(8'h0E, 8'h01);
    reg_is(8'h0E, 8'h01);
    u_host.wr(8'h03, 8'h40);
    reg_is(8'h03, 8'h70);
    `CHK(locked, 1'b1)
    push({8'h85});
    reg_is(8'h03, 8'h60);
    push({8'h86});
    reg_is(8'h02, 8'h04);
    `CHK(int_n, 1'b0)
    reg_is(8'h03, 8'h00);
    u_host.wr(8'h02, 8'h04);
    @(posedge mclk);
    key1 <= 8'h00;
    u_host.wr(8'h03, 8'h40);
    reg_is(8'h03, 8'h40);
    `CHK(locked, 1'b0)
    u_host.wr(8'h03, 8'h00);
    $display("t_lock done");
  endtask
  // Mask timer flags the first locked press; window runs out
  task automatic t_lock_timers;
    @(posedge mclk);
    cfg <= 8'h05;
    key1 <= 8'h05;
    u_host.wr(8'h0E, 8'h09);
    u_host.wr(8'h03, 8'h40);
    push({8'h85});
    reg_is(8'h02, 8'h01);
    `CHK(int_oe, 1'b1)
    reg_is(8'h03, 8'h60);
    // One second is 50 cycles here; wait past it
    repeat (60) @(posedge mclk);
    reg_is(8'h03, 8'h70);
    push({8'h86});
    reg_is(8'h02, 8'h01);
    u_host.wr(8'h03, 8'h00);
    reg_is(8'h03, 8'h00);
    u_host.wr(8'h02, 8'h01);
    reg_is(8'h02, 8'h00);
    $display("t_lock_timers done");
  endtask
  // Pending clear in reassert mode drops the pin for 20 cycles
  task automatic t_reassert;
    @(posedge mclk);
    cfg <= 8'h11;
    push({8'h81});
    u_host.wr(8'h02, 8'h01);
    @(negedge mclk);
    `CHK(int_n, 1'b1)
    repeat (25) @(posedge mclk);
    @(negedge mclk);
    `CHK(int_n, 1'b0)
    u_host.drain(q);
    $display("t_reassert done");
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_queue;
    t_overflow;
    t_combo;
    t_gpi;
    t_lock;
    t_lock_timers;
    t_reassert;
    tally_and_finish;
  end
  // Hang guard, well above the expected run
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
endmodule
`default_nettype wire
